// file: hdl/sbc_pkg.sv
// Purpose: Shared constants and helpers for the SDRAM command link
// Assumes: 25 MHz core clock, 16-bit data, 4 banks of 4096 rows x 512 columns
// Notes: Command code is {cs_n, ras_n, cas_n, we_n}
package sbc_pkg;
    localparam int BANK_W = 2;
    localparam int ROW_W = 12;
    localparam int COL_W = 9;
    localparam int MEM_AW = BANK_W + ROW_W + COL_W;

    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;

    localparam int AP_BIT = 10;
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BT_BIT = 3;
    localparam int MODE_CL_LSB = 4;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [11:0] MODE_RESET = 12'h022;

    localparam int CLK_PERIOD_NS = 40;
    localparam int REF_WINDOW_MS = 64;
    localparam int REF_ROWS = 4096;
    localparam int REF_INTERVAL_CYC = REF_WINDOW_MS * 1000000 / REF_ROWS / CLK_PERIOD_NS;
    localparam int REF_MARGIN_CYC = 30;
    localparam int ROW_CYCLE_NS = 63;
    localparam int ROW_CYCLE_CYC = (ROW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_BEATS = 8;

    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [2:0] REG_BUF_PAGE = 3'h1;
    localparam int OP_GO = 0;
    localparam int OP_WR = 1;
    localparam int OP_AP = 2;
    localparam int OP_LOAD = 3;
    localparam int OP_SR_IN = 4;
    localparam int OP_SR_OUT = 5;
    localparam int OP_MASK_LSB = 6;

    function automatic logic [9:0] burst_len(input logic [2:0] code);
        case (code)
            BL_2: burst_len = 10'h002;
            BL_4: burst_len = 10'h004;
            BL_8: burst_len = 10'h008;
            BL_PAGE: burst_len = 10'h200;
            default: burst_len = 10'h001;
        endcase
    endfunction

    function automatic logic [8:0] burst_col(input logic [8:0] start, input logic [8:0] cnt,
                                             input logic [2:0] code, input logic inter);
        logic [8:0] wrap;
        logic [8:0] low;
        wrap = 9'(burst_len(code) - 10'h001);
        low = (inter && code != BL_PAGE) ? (start ^ cnt) : 9'(start + cnt);
        burst_col = (start & ~wrap) | (low & wrap);
    endfunction

    function automatic logic [3:0] xfer_beats(input logic [2:0] code);
        xfer_beats = (code == BL_PAGE) ? 4'(MAX_BEATS) : 4'(burst_len(code));
    endfunction
endpackage

// file: hdl/sbc_if.sv
// Purpose: Pin bundle between controller and memory device
// Assumes: Both ends clocked by the same core_clk
// Notes: Data lanes resolved per byte from the two output enables
`timescale 1ns/1ps
interface sbc_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [11:0] addr;
    logic [1:0] bank_select;
    logic low_byte_mask;
    logic high_byte_mask;
    logic [15:0] dq_ctl;
    logic [1:0] dq_ctl_oe;
    logic [15:0] dq_dev;
    logic [1:0] dq_dev_oe;
    wire [15:0] dq;

    // Undriven lanes read as zero; nothing samples them outside a transfer
    assign dq[7:0] = dq_dev_oe[0] ? dq_dev[7:0] : (dq_ctl_oe[0] ? dq_ctl[7:0] : 8'h00);
    assign dq[15:8] = dq_dev_oe[1] ? dq_dev[15:8] : (dq_ctl_oe[1] ? dq_ctl[15:8] : 8'h00);

    modport ctl (output cke, cs_n, ras_n, cas_n, we_n, addr, bank_select, low_byte_mask,
                 high_byte_mask, dq_ctl, dq_ctl_oe, input dq);
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, addr, bank_select, low_byte_mask,
                 high_byte_mask, dq, output dq_dev, dq_dev_oe);
endinterface

// file: hdl/sbc_dev.sv
// Purpose: Synchronous DRAM device end: command decode, banks, bursts
// Assumes: Controller on the same clock presents pins after each rising edge
// Notes: Full-page bursts run until stopped; auto precharge ignored there
// Contract
// R01: Inputs registered on rising clock edge.
// R02: Controller opens a row before access.
// R03: Four banks of 2M 16-bit words.
// R04: Burst length 1, 2, 4, 8 or page.
// R05: Sequential or interleaved burst column order.
// R06: Read data after CAS latency 2 or 3.
// R07: Burst stop ends a burst early.
// R08: Auto precharge closes row after burst.
// R09: Burst counter and outputs advance each edge.
// R10: Controller refreshes 4096 rows per 64 ms.
// R11: Auto refresh and self refresh both supported.
// R12: Clock enable low freezes next cycle onward.
// R13: Power down or self refresh only idle.
// R14: Controller loads mode before first access.
// R15: Controller tracks rows, precharges before reopening.
`timescale 1ns/1ps
module sbc_dev (
    input wire logic core_clk, // 25 MHz clock
    input wire logic srst, // Sync reset, active high
    sbc_if.dev mem, // Memory pins
    output logic self_refresh_active, // Held in self refresh
    output logic power_down_active, // Held in power down
    output logic [3:0] bank_open, // Row open per bank
    output logic [11:0] refresh_row // Next row auto refresh visits
);
    logic [15:0] store [0:(1 << sbc_pkg::MEM_AW) - 1];
    logic [11:0] row_reg [0:3];
    logic cke_reg;
    logic sr_reg;
    logic pd_reg;
    logic [11:0] mode_reg;
    logic [11:0] ref_row_reg;
    logic [3:0] open_reg;
    logic bact_reg;
    logic bwr_reg;
    logic bap_reg;
    logic [1:0] bbank_reg;
    logic [8:0] bstart_reg;
    logic [8:0] bcnt_reg;
    logic [15:0] p1_reg;
    logic [15:0] p2_reg;
    logic [15:0] dq_reg;
    logic v1_reg;
    logic v2_reg;
    logic [1:0] mask_reg;
    logic [1:0] oe_reg;

    // R01 command sampled
    wire [3:0] cmd;
    assign cmd = mem.cs_n ? sbc_pkg::CMD_NOP : {1'b0, mem.ras_n, mem.cas_n, mem.we_n};

    wire [2:0] bl_code;
    wire bt_inter;
    wire cl3;
    assign bl_code = mode_reg[sbc_pkg::MODE_BL_LSB +: 3];
    assign bt_inter = mode_reg[sbc_pkg::MODE_BT_BIT];
    assign cl3 = mode_reg[sbc_pkg::MODE_CL_LSB +: 3] == sbc_pkg::CL_3;

    // R12 suspend after low
    wire run;
    assign run = cke_reg & ~sr_reg;

    wire all_idle;
    wire acc;
    wire pre_hit;
    wire halt;
    wire go;
    assign all_idle = (open_reg == 4'h0) & ~bact_reg;
    assign acc = run & (cmd == sbc_pkg::CMD_READ | cmd == sbc_pkg::CMD_WRITE);
    assign pre_hit = (cmd == sbc_pkg::CMD_PRE)
                   & (mem.addr[sbc_pkg::AP_BIT] | mem.bank_select == bbank_reg);
    // R07 stop ends burst
    assign halt = run & (cmd == sbc_pkg::CMD_BST | pre_hit);
    assign go = acc | (run & bact_reg & ~halt);

    wire [1:0] bk;
    wire [8:0] col;
    wire wr;
    wire ap;
    wire [8:0] cur;
    wire last;
    wire [22:0] idx;
    assign bk = acc ? mem.bank_select : bbank_reg;
    // R05 column order
    assign col = acc ? mem.addr[8:0]
                     : sbc_pkg::burst_col(bstart_reg, bcnt_reg, bl_code, bt_inter);
    assign wr = acc ? (cmd == sbc_pkg::CMD_WRITE) : bwr_reg;
    assign ap = acc ? mem.addr[sbc_pkg::AP_BIT] : bap_reg;
    assign cur = acc ? 9'h000 : bcnt_reg;
    // R04 programmed length
    assign last = (bl_code != sbc_pkg::BL_PAGE)
                & ({1'b0, cur} == sbc_pkg::burst_len(bl_code) - 10'h001);
    // R03 bank row column
    assign idx = {bk, row_reg[bk], col};

    // R13 entry only idle
    wire sr_enter;
    assign sr_enter = run & (cmd == sbc_pkg::CMD_REF) & ~mem.cke & all_idle;

    // Array and row latches carry no reset: contents are data, not control
    always_ff @(posedge core_clk) begin
        if (go & wr & ~mem.low_byte_mask) begin
            store[idx][7:0] <= mem.dq[7:0];
        end
        if (go & wr & ~mem.high_byte_mask) begin
            store[idx][15:8] <= mem.dq[15:8];
        end
        if (run & cmd == sbc_pkg::CMD_ACT) begin
            row_reg[mem.bank_select] <= mem.addr;
        end
    end

    // R06 latency pipeline
    always_ff @(posedge core_clk) begin
        if (srst) begin
            p1_reg <= 16'h0000;
            p2_reg <= 16'h0000;
            dq_reg <= 16'h0000;
            v1_reg <= 1'b0;
            v2_reg <= 1'b0;
            mask_reg <= 2'h0;
            oe_reg <= 2'h0;
        end else if (run) begin
            // R09 outputs each edge
            mask_reg <= {mem.high_byte_mask, mem.low_byte_mask};
            p1_reg <= store[idx];
            v1_reg <= go & ~wr;
            p2_reg <= p1_reg;
            v2_reg <= v1_reg;
            dq_reg <= cl3 ? p2_reg : p1_reg;
            // Mask two edges ahead of the data it hides
            oe_reg <= {2{cl3 ? v2_reg : v1_reg}} & ~mask_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cke_reg <= 1'b1;
            sr_reg <= 1'b0;
            pd_reg <= 1'b0;
            mode_reg <= sbc_pkg::MODE_RESET;
            ref_row_reg <= 12'h000;
            open_reg <= 4'h0;
            bact_reg <= 1'b0;
            bwr_reg <= 1'b0;
            bap_reg <= 1'b0;
            bbank_reg <= 2'h0;
            bstart_reg <= 9'h000;
            bcnt_reg <= 9'h000;
        end else begin
            cke_reg <= mem.cke;
            // R13 power down idle
            pd_reg <= ~mem.cke & all_idle & ~sr_reg & ~sr_enter;
            // Self refresh exit takes cke without a command
            if (sr_reg & mem.cke) begin
                sr_reg <= 1'b0;
            end
            if (run) begin
                case (cmd)
                    sbc_pkg::CMD_MRS: begin
                        if (all_idle) begin
                            mode_reg <= mem.addr;
                        end
                    end
                    sbc_pkg::CMD_ACT: begin
                        open_reg[mem.bank_select] <= 1'b1;
                    end
                    sbc_pkg::CMD_PRE: begin
                        if (mem.addr[sbc_pkg::AP_BIT]) begin
                            open_reg <= 4'h0;
                        end else begin
                            open_reg[mem.bank_select] <= 1'b0;
                        end
                    end
                    // R11 auto and self refresh
                    sbc_pkg::CMD_REF: begin
                        if (all_idle) begin
                            ref_row_reg <= ref_row_reg + 12'h001;
                            sr_reg <= ~mem.cke;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (acc) begin
                bact_reg <= ~last;
                bwr_reg <= cmd == sbc_pkg::CMD_WRITE;
                bap_reg <= mem.addr[sbc_pkg::AP_BIT];
                bbank_reg <= mem.bank_select;
                bstart_reg <= mem.addr[8:0];
                bcnt_reg <= 9'h001;
            end else if (halt) begin
                bact_reg <= 1'b0;
            end else if (go) begin
                // R09 counter advances
                bcnt_reg <= bcnt_reg + 9'h001;
                if (last) begin
                    bact_reg <= 1'b0;
                end
            end
            // R08 self-timed precharge
            if (go & last & ap) begin
                open_reg[bk] <= 1'b0;
            end
        end
    end

    assign mem.dq_dev = dq_reg;
    assign mem.dq_dev_oe = oe_reg;
    assign self_refresh_active = sr_reg;
    assign power_down_active = pd_reg;
    assign bank_open = open_reg;
    assign refresh_row = ref_row_reg;
endmodule

// file: hdl/sbc_ctl.sv
// Purpose: Controller end: opens rows, bursts, refreshes, self refresh
// Assumes: Software loads the mode before accesses; one job at a time
// Notes: Moves at most eight words per access; page mode ends by burst stop
`timescale 1ns/1ps
module sbc_ctl (
    input wire logic core_clk, // 25 MHz clock
    input wire logic srst, // Sync reset, active high
    sbc_if.ctl mem, // Memory pins
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic [31:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata // Read data, cycle after strobe
);
    typedef enum logic [3:0] {
        S_IDLE, S_RW, S_XFER, S_SR, S_WAIT
    } sbc_ctl_state_t;

    sbc_ctl_state_t st_reg;
    sbc_ctl_state_t ret_reg;
    logic [3:0] wait_reg;
    logic [11:0] mode_reg;
    logic mode_ok_reg;
    logic [22:0] addr_reg;
    logic [7:0] op_reg;
    logic refused_reg;
    logic [8:0] ref_cnt_reg;
    logic ref_due_reg;
    logic [3:0] open_reg;
    logic [11:0] row_reg [0:3];
    logic [15:0] buf_mem [0:7];
    logic [3:0] cnt_reg;
    logic cke_reg;
    logic [3:0] cmd_reg;
    logic [11:0] a_reg;
    logic [1:0] ba_reg;
    logic [15:0] dqo_reg;
    logic [1:0] dqoe_reg;
    logic [1:0] msk_reg;
    logic [31:0] rdata_reg;

    wire [1:0] bank;
    wire [11:0] row;
    wire [2:0] bl;
    wire page;
    wire [3:0] n;
    wire [3:0] cl;
    wire is_wr;
    wire xfer_end;
    wire cap;
    wire [2:0] cap_idx;
    wire ref_fire;
    wire busy;
    assign bank = addr_reg[22:21];
    assign row = addr_reg[20:9];
    assign bl = mode_reg[sbc_pkg::MODE_BL_LSB +: 3];
    assign page = bl == sbc_pkg::BL_PAGE;
    assign n = sbc_pkg::xfer_beats(bl);
    assign cl = {1'b0, mode_reg[sbc_pkg::MODE_CL_LSB +: 3]};
    assign is_wr = op_reg[sbc_pkg::OP_WR];
    assign xfer_end = cnt_reg == (is_wr ? n : cl + n);
    // R06 capture after latency
    assign cap = (st_reg == S_XFER) & ~is_wr & (cnt_reg > cl) & (cnt_reg <= cl + n);
    assign cap_idx = 3'(cnt_reg - cl - 4'h1);
    // R10 evenly spaced refresh
    assign ref_fire = ref_cnt_reg == 9'(sbc_pkg::REF_INTERVAL_CYC - sbc_pkg::REF_MARGIN_CYC);
    assign busy = (st_reg != S_IDLE) | (op_reg != 8'h00);

    wire wr_mode;
    wire wr_addr;
    wire wr_cmd;
    wire wr_buf;
    wire cmd_bad;
    wire [31:0] rd_val;
    assign wr_mode = reg_wr & reg_addr == sbc_pkg::REG_MODE;
    assign wr_addr = reg_wr & reg_addr == sbc_pkg::REG_ADDR;
    assign wr_cmd = reg_wr & reg_addr == sbc_pkg::REG_CMD;
    assign wr_buf = reg_wr & reg_addr[7:5] == sbc_pkg::REG_BUF_PAGE & reg_addr[1:0] == 2'h0;
    // R14 no access before mode
    assign cmd_bad = (op_reg != 8'h00) | (reg_wdata[sbc_pkg::OP_GO] & ~mode_ok_reg);
    assign rd_val = (reg_addr == sbc_pkg::REG_MODE) ? {20'h0_0000, mode_reg}
                  : (reg_addr == sbc_pkg::REG_ADDR) ? {9'h000, addr_reg}
                  : (reg_addr == sbc_pkg::REG_STATUS)
                    ? {28'h000_0000, refused_reg, st_reg == S_SR, mode_ok_reg, busy}
                  : (reg_addr[7:5] == sbc_pkg::REG_BUF_PAGE & reg_addr[1:0] == 2'h0)
                    ? {16'h0000, buf_mem[reg_addr[4:2]]} : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (cap) begin
            buf_mem[cap_idx] <= mem.dq;
        end else if (wr_buf) begin
            buf_mem[reg_addr[4:2]] <= reg_wdata[15:0];
        end
        if (st_reg == S_IDLE & op_reg[sbc_pkg::OP_GO] & ~open_reg[bank]) begin
            row_reg[bank] <= row;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= reg_rd ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_reg <= S_IDLE;
            ret_reg <= S_IDLE;
            wait_reg <= 4'h0;
            mode_reg <= sbc_pkg::MODE_RESET;
            mode_ok_reg <= 1'b0;
            addr_reg <= 23'h00_0000;
            op_reg <= 8'h00;
            refused_reg <= 1'b0;
            ref_cnt_reg <= 9'h000;
            ref_due_reg <= 1'b0;
            open_reg <= 4'h0;
            cnt_reg <= 4'h0;
            cke_reg <= 1'b1;
            cmd_reg <= sbc_pkg::CMD_NOP;
            a_reg <= 12'h000;
            ba_reg <= 2'h0;
            dqo_reg <= 16'h0000;
            dqoe_reg <= 2'h0;
            msk_reg <= 2'h0;
        end else begin
            cmd_reg <= sbc_pkg::CMD_NOP;
            if (wr_mode & ~busy) begin
                mode_reg <= reg_wdata[11:0];
            end
            if (wr_addr & ~busy) begin
                addr_reg <= reg_wdata[22:0];
            end
            if (wr_cmd & ~cmd_bad) begin
                op_reg <= reg_wdata[7:0];
            end
            if (reg_rd & reg_addr == sbc_pkg::REG_STATUS) begin
                refused_reg <= 1'b0;
            end
            ref_cnt_reg <= (st_reg == S_SR | ref_fire) ? 9'h000 : ref_cnt_reg + 9'h001;
            case (st_reg)
                S_IDLE: begin
                    wait_reg <= 4'(sbc_pkg::ROW_CYCLE_CYC);
                    ret_reg <= S_IDLE;
                    // R13 close banks first
                    if ((ref_due_reg | op_reg[sbc_pkg::OP_LOAD] | op_reg[sbc_pkg::OP_SR_IN])
                        & open_reg != 4'h0) begin
                        cmd_reg <= sbc_pkg::CMD_PRE;
                        a_reg <= 12'h400;
                        open_reg <= 4'h0;
                        st_reg <= S_WAIT;
                    end else if (ref_due_reg) begin
                        cmd_reg <= sbc_pkg::CMD_REF;
                        ref_due_reg <= 1'b0;
                        st_reg <= S_WAIT;
                    end else if (op_reg[sbc_pkg::OP_LOAD]) begin
                        cmd_reg <= sbc_pkg::CMD_MRS;
                        a_reg <= mode_reg;
                        mode_ok_reg <= 1'b1;
                        op_reg <= 8'h00;
                        st_reg <= S_WAIT;
                    end else if (op_reg[sbc_pkg::OP_SR_IN]) begin
                        cmd_reg <= sbc_pkg::CMD_REF;
                        cke_reg <= 1'b0;
                        op_reg <= 8'h00;
                        st_reg <= S_SR;
                    end else if (op_reg[sbc_pkg::OP_GO]) begin
                        ba_reg <= bank;
                        // R15 precharge other row
                        if (open_reg[bank] & row_reg[bank] == row) begin
                            st_reg <= S_RW;
                        end else if (open_reg[bank]) begin
                            cmd_reg <= sbc_pkg::CMD_PRE;
                            a_reg <= 12'h000;
                            open_reg[bank] <= 1'b0;
                            st_reg <= S_WAIT;
                        end else begin
                            // R02 activate before access
                            cmd_reg <= sbc_pkg::CMD_ACT;
                            a_reg <= row;
                            open_reg[bank] <= 1'b1;
                            ret_reg <= S_RW;
                            st_reg <= S_WAIT;
                        end
                    end
                end
                S_RW: begin
                    cmd_reg <= is_wr ? sbc_pkg::CMD_WRITE : sbc_pkg::CMD_READ;
                    a_reg <= {1'b0, op_reg[sbc_pkg::OP_AP] & ~page, 1'b0, addr_reg[8:0]};
                    cnt_reg <= 4'h1;
                    dqo_reg <= buf_mem[0];
                    dqoe_reg <= {2{is_wr}};
                    msk_reg <= is_wr ? op_reg[sbc_pkg::OP_MASK_LSB +: 2] : 2'h0;
                    st_reg <= S_XFER;
                end
                S_XFER: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (is_wr & cnt_reg < n) begin
                        dqo_reg <= buf_mem[cnt_reg[2:0]];
                    end else begin
                        dqoe_reg <= 2'h0;
                        msk_reg <= 2'h0;
                    end
                    // Page bursts never end on their own
                    if (page & cnt_reg == 4'(sbc_pkg::MAX_BEATS)) begin
                        cmd_reg <= sbc_pkg::CMD_BST;
                    end
                    if (xfer_end) begin
                        if (op_reg[sbc_pkg::OP_AP] & ~page) begin
                            open_reg[bank] <= 1'b0;
                        end
                        op_reg <= 8'h00;
                        ret_reg <= S_IDLE;
                        wait_reg <= 4'(sbc_pkg::ROW_CYCLE_CYC);
                        st_reg <= S_WAIT;
                    end
                end
                S_SR: begin
                    if (op_reg[sbc_pkg::OP_SR_OUT]) begin
                        cke_reg <= 1'b1;
                        op_reg <= 8'h00;
                        st_reg <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    wait_reg <= wait_reg - 4'h1;
                    if (wait_reg <= 4'h1) begin
                        st_reg <= ret_reg;
                    end
                end
                default: begin
                    st_reg <= S_IDLE;
                end
            endcase
            // Set wins over the clear above
            if (ref_fire & st_reg != S_SR) begin
                ref_due_reg <= 1'b1;
            end
            if (wr_cmd & cmd_bad) begin
                refused_reg <= 1'b1;
            end
        end
    end

    assign mem.cke = cke_reg;
    assign mem.cs_n = cmd_reg[3];
    assign mem.ras_n = cmd_reg[2];
    assign mem.cas_n = cmd_reg[1];
    assign mem.we_n = cmd_reg[0];
    assign mem.addr = a_reg;
    assign mem.bank_select = ba_reg;
    assign mem.low_byte_mask = msk_reg[0];
    assign mem.high_byte_mask = msk_reg[1];
    assign mem.dq_ctl = dqo_reg;
    assign mem.dq_ctl_oe = dqoe_reg;
    assign reg_rdata = rdata_reg;
endmodule

// file: verif/sbc_link_properties.sv
// Purpose: Pin-level checks on the link
// Assumes: One clock, sync reset
// Notes: Watches the bundle only
`timescale 1ns/1ps
module sbc_link_properties (
    input wire logic core_clk, // Clock
    input wire logic srst, // Reset
    input wire logic cke, // Clock enable
    input wire logic cs_n, // Select
    input wire logic ras_n, // Row strobe
    input wire logic cas_n, // Column strobe
    input wire logic we_n, // Write enable
    input wire logic [1:0] dq_ctl_oe, // Ctl drive
    input wire logic [1:0] dq_dev_oe // Dev drive
);
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire quiet = cs_n || cmd == sbc_pkg::CMD_NOP;
    wire [1:0] oe = dq_ctl_oe | dq_dev_oe;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence quiet2; quiet [*2]; endsequence
    a_no_bus_fight: assert property ((dq_ctl_oe & dq_dev_oe) == 2'h0)
        else $error("dq driven by both ends");
    a_read_data_due: assert property (
        cke && cmd == sbc_pkg::CMD_READ |-> ##[2:3] dq_dev_oe != 2'h0) else $error("no read data");
    a_act_settle: assert property (cke && cmd == sbc_pkg::CMD_ACT |=> quiet2)
        else $error("command too soon after row open");
    a_pre_settle: assert property (cke && cmd == sbc_pkg::CMD_PRE |=> quiet2)
        else $error("command too soon after precharge");
    a_ref_settle: assert property (
        cke && (cmd == sbc_pkg::CMD_REF || cmd == sbc_pkg::CMD_MRS) |=> quiet2)
        else $error("command too soon after refresh or mode");
    a_mode_idle: assert property (
        cmd == sbc_pkg::CMD_MRS || cmd == sbc_pkg::CMD_REF |-> oe == 2'h0)
        else $error("mode or refresh during transfer");
    a_cke_fall_idle: assert property ($fell(cke) |-> oe == 2'h0)
        else $error("clock enable dropped during transfer");
    a_frozen_quiet: assert property (
        !cke && !$past(cke) |-> quiet || cmd == sbc_pkg::CMD_REF)
        else $error("command while clock suspended");
endmodule

// file: verif/test_sdram_burst_command_interface.sv
// Purpose: Register-driven bursts across both ends
// Assumes: 25 MHz clock, reset held 8 cycles
// Notes: Buffer cleared before reads so stale words cannot pass
`timescale 1ns/1ps
module test_sdram_burst_command_interface;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic sr_on;
    logic [3:0] bank_open;
    logic [11:0] refresh_row;
    int failures = 0;
    int tests_run = 0;
    sbc_if i_sbc_if ();
    sbc_ctl i_sbc_ctl (.core_clk(core_clk), .srst(srst), .mem(i_sbc_if), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    sbc_dev i_sbc_dev (.core_clk(core_clk), .srst(srst), .mem(i_sbc_if), .bank_open(bank_open),
        .self_refresh_active(sr_on), .power_down_active(), .refresh_row(refresh_row));
    sbc_link_properties i_sbc_link_properties (.core_clk(core_clk), .srst(srst),
        .cke(i_sbc_if.cke), .cs_n(i_sbc_if.cs_n), .ras_n(i_sbc_if.ras_n), .cas_n(i_sbc_if.cas_n),
        .we_n(i_sbc_if.we_n), .dq_ctl_oe(i_sbc_if.dq_ctl_oe), .dq_dev_oe(i_sbc_if.dq_dev_oe));
    initial forever #20 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic go(input logic [31:0] c);
        logic [31:0] s;
        wr(8'h08, c);
        for (int n = 0; n < 200; n++) begin
            rd(8'h0C, s);
            if (s[0] === 1'b0) return;
        end
        chk(s & 32'h0000_0001, 32'h0000_0000);
    endtask
    // Retry: a refresh in progress makes the controller drop mode and address writes
    task automatic set(input logic [7:0] a, input logic [31:0] v, output logic [31:0] d);
        wr(a, v);
        rd(a, d);
        if (d !== v) set(a, v, d);
    endtask
    // Words read back as 16'hA000 plus their column
    task automatic burst_read(input logic [11:0] m, input logic [8:0] col);
        logic [8:0] w, c;
        logic [31:0] d;
        w = (m[2:0] == 3'h7) ? 9'h1FF : 9'((1 << m[2:0]) - 1);
        set(8'h00, 32'(m), d);
        go(32'h0000_0008);
        for (int i = 0; i < 8; i++) wr(8'(32 + 4 * i), 32'h0000_0000);
        set(8'h04, 32'h0020_0A00 | 32'(col), d);
        go(32'h0000_0001);
        for (int i = 0; i < ((m[2:0] == 3'h7) ? 8 : (1 << m[2:0])); i++) begin
            c = (m[3] && w != 9'h1FF) ? col ^ 9'(i) : col + 9'(i);
            rd(8'(32 + 4 * i), d);
            chk(d, 32'h0000_A000 | 32'((col & ~w) | (c & w)));
        end
    endtask
    task automatic test_refuse();
        logic [31:0] d;
        wr(8'h08, 32'h0000_0001);
        rd(8'h0C, d);
        chk(d, 32'h0000_0008);
        rd(8'h0C, d);
        chk(d, 32'h0000_0000);
        rd(8'h40, d);
        chk(d, 32'h0000_0000);
        $display("refuse done");
    endtask
    task automatic test_write();
        wr(8'h00, 32'h0000_0023);
        go(32'h0000_0008);
        for (int i = 0; i < 8; i++) wr(8'(32 + 4 * i), 32'h0000_A000 + 32'(i));
        wr(8'h04, 32'h0020_0A00);
        go(32'h0000_0007);
        chk(32'(bank_open), 32'h0000_0000);
        $display("write done");
    endtask
    task automatic test_orders();
        burst_read(12'h032, 9'h006);
        burst_read(12'h02A, 9'h001);
        burst_read(12'h03B, 9'h005);
        burst_read(12'h021, 9'h003);
        burst_read(12'h020, 9'h007);
        burst_read(12'h027, 9'h000);
        $display("orders done");
    endtask
    task automatic test_self_refresh();
        logic [31:0] d;
        logic [11:0] r;
        r = refresh_row;
        repeat (400) @(posedge core_clk);
        chk(32'(refresh_row != r), 32'h0000_0001);
        wr(8'h08, 32'h0000_0010);
        repeat (10) @(posedge core_clk);
        rd(8'h0C, d);
        chk(d, 32'h0000_0007);
        chk(32'(sr_on), 32'h0000_0001);
        go(32'h0000_0020);
        chk(32'(sr_on), 32'h0000_0000);
        burst_read(12'h022, 9'h004);
        $display("self refresh done");
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        test_refuse();
        test_write();
        test_orders();
        test_self_refresh();
        results();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        results();
    end
endmodule
